// File: design/psp_consts.vh
// constants and register map for the pin strap and port enable block
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// =====================================================
// register map; control register numbers are word indices, the apb byte address is four times the index
`define PSP_IDX_XCTRL 10'h083
`define PSP_IDX_ICTRL 10'h087
`define PSP_IDX_XFMT 10'h092
`define PSP_ADDR_XCTRL {`PSP_IDX_XCTRL, 2'b00}
`define PSP_ADDR_ICTRL {`PSP_IDX_ICTRL, 2'b00}
`define PSP_ADDR_XFMT {`PSP_IDX_XFMT, 2'b00}
`define PSP_ADDR_STRAP 12'h0F0
`define PSP_ADDR_TAPST 12'h0F4

// =====================================================
// fields
`define PSP_XPORT_EN_LSB 0
`define PSP_IPORT_EN_LSB 0
`define PSP_VREF_FORM_LSB 4
`define PSP_XCTRL_RST 32'h0000_0000
`define PSP_ICTRL_RST 32'h0000_0000
`define PSP_XFMT_RST 32'h0000_0000

// =====================================================
// strap decodes
`define PSP_SLV_ADDR_LO 7'h21
`define PSP_SLV_ADDR_HI 7'h20
`define PSP_XTAL_KHZ_LO 16'h6000
`define PSP_XTAL_KHZ_HI 16'h7D6E

// =====================================================
// tap states
`define PSP_TAP_RESET 4'h0
`define PSP_TAP_IDLE 4'h1
`define PSP_TAP_SEL_DR 4'h2
`define PSP_TAP_CAP_DR 4'h3
`define PSP_TAP_SH_DR 4'h4
`define PSP_TAP_EX1_DR 4'h5
`define PSP_TAP_PA_DR 4'h6
`define PSP_TAP_EX2_DR 4'h7
`define PSP_TAP_UP_DR 4'h8
`define PSP_TAP_SEL_IR 4'h9
`define PSP_TAP_CAP_IR 4'hA
`define PSP_TAP_SH_IR 4'hB
`define PSP_TAP_EX1_IR 4'hC
`define PSP_TAP_PA_IR 4'hD
`define PSP_TAP_EX2_IR 4'hE
`define PSP_TAP_UP_IR 4'hF

`endif

// File: design/psp_top.v
// pin strap capture, test port and video port output-enable control
`timescale 1ns/10ps
`include "psp_consts.vh"

module psp_top
#(
  parameter XW = 8,
  parameter IW = 8
)
(
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // straps
  input wire address_strap_pin_i,
  input wire crystal_select_strap_pin_i,
  output wire address_strap_pin_oe,
  output wire crystal_select_strap_pin_oe,
  output wire strap_pulldown_en,
  output wire [6:0] slave_addr,
  output wire xtal_is_high,
  output wire [15:0] xtal_khz,
  // test port (sampled in pclk domain)
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output wire tdo_o,
  output wire tdo_oe,
  output wire test_pullup_en,
  // expansion port
  input wire expansion_port_output_control_pin,
  input wire [XW-1:0] dec_data,
  input wire dec_clk,
  input wire dec_qual,
  input wire dec_ready,
  input wire dec_href,
  input wire dec_vref,
  input wire dec_vsync,
  input wire dec_vgate,
  input wire [XW-1:0] expansion_port_data_pins_i,
  output wire [XW-1:0] expansion_port_data_pins_o,
  output wire [XW-1:0] expansion_port_data_pins_oe,
  output wire expansion_port_clock_pin_o,
  output wire expansion_port_clock_pin_oe,
  output wire expansion_port_qualifier_pin_o,
  output wire expansion_port_qualifier_pin_oe,
  output wire expansion_port_ready_pin_o,
  output wire expansion_port_ready_pin_oe,
  output wire expansion_horizontal_ref_pin_o,
  output wire expansion_horizontal_ref_pin_oe,
  output wire expansion_vertical_ref_pin_o,
  output wire expansion_vertical_ref_pin_oe,
  output wire [XW-1:0] xport_in_data,
  // image port
  input wire image_port_oe_pin,
  input wire [IW-1:0] scl_main,
  input wire [IW-1:0] scl_chroma,
  input wire scl_clk,
  input wire scl_qual,
  output wire [IW-1:0] image_port_main_data_pins_o,
  output wire image_port_main_data_pins_oe,
  output wire [IW-1:0] image_port_chroma_pins_o,
  output wire image_port_chroma_pins_oe,
  output wire image_port_clock_pin_o,
  output wire image_port_clock_pin_oe,
  output wire image_port_qualifier_pin_o,
  output wire image_port_qualifier_pin_oe,
  // oscillator
  input wire xtal_osc,
  output wire aux_oscillator_output
);

  // =====================================================
  // strap capture
  reg in_reset_q;
  reg addr_strap_q;
  reg xtal_strap_q;

  // flag is high in reset and clears at the first edge after release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_reset_q <= 1'b1;
    else
      in_reset_q <= 1'b0;
  end

  // sample only on the release edge, then freeze so straps may be reused
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_strap_q <= 1'b0;
      xtal_strap_q <= 1'b0;
    end
    else if (in_reset_q)
    begin
      addr_strap_q <= address_strap_pin_i;
      xtal_strap_q <= crystal_select_strap_pin_i;
    end
  end

  // straps stay inputs for good; later output use of these pins is not modelled
  assign address_strap_pin_oe = 1'b0;
  assign crystal_select_strap_pin_oe = 1'b0;
  assign strap_pulldown_en = 1'b1; // open pins read low
  assign slave_addr = addr_strap_q ? `PSP_SLV_ADDR_HI : `PSP_SLV_ADDR_LO;
  assign xtal_is_high = xtal_strap_q;
  assign xtal_khz = xtal_strap_q ? `PSP_XTAL_KHZ_HI : `PSP_XTAL_KHZ_LO;

  // =====================================================
  // registers
  // control fields, all zero after reset so every port starts released
  reg [1:0] xport_en_q;
  reg [1:0] iport_en_q;
  reg [1:0] vref_form_q;
  reg [31:0] rdata_q;
  reg slverr_q;
  reg [3:0] tap_q;
  wire wr_en;
  wire rd_setup;
  reg [31:0] rd_mux;
  reg hit;

  // a write lands only at the access edge; no wait states are ever inserted
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1; // zero wait states
  assign prdata = rdata_q;
  assign pslverr = slverr_q & psel & penable;

  // read mux and decode
  // full-address match, so any alias answers with an error
  always @*
  begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `PSP_ADDR_XCTRL: rd_mux[`PSP_XPORT_EN_LSB+1:`PSP_XPORT_EN_LSB] = xport_en_q;
      `PSP_ADDR_ICTRL: rd_mux[`PSP_IPORT_EN_LSB+1:`PSP_IPORT_EN_LSB] = iport_en_q;
      `PSP_ADDR_XFMT: rd_mux[`PSP_VREF_FORM_LSB+1:`PSP_VREF_FORM_LSB] = vref_form_q;
      `PSP_ADDR_STRAP: rd_mux[1:0] = {xtal_strap_q, addr_strap_q};
      `PSP_ADDR_TAPST: rd_mux[3:0] = tap_q;
      default: hit = 1'b0;
    endcase
  end

  // read data registered in setup so it is stable across access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (rd_setup)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      slverr_q <= !hit;
    end
  end

  // control writes; straps and tap state are read-only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xport_en_q <= 2'b00;
      iport_en_q <= 2'b00;
      vref_form_q <= 2'b00;
    end
    else if (wr_en)
    begin
      case (paddr)
        `PSP_ADDR_XCTRL: xport_en_q <= pwdata[`PSP_XPORT_EN_LSB+1:`PSP_XPORT_EN_LSB];
        `PSP_ADDR_ICTRL: iport_en_q <= pwdata[`PSP_IPORT_EN_LSB+1:`PSP_IPORT_EN_LSB];
        `PSP_ADDR_XFMT: vref_form_q <= pwdata[`PSP_VREF_FORM_LSB+1:`PSP_VREF_FORM_LSB];
        default: xport_en_q <= xport_en_q;
      endcase
    end
  end

  // =====================================================
  // test access port, tck edge found in pclk domain
  // tap state is readable on the bus, handy at bring-up
  reg tck_q;
  reg tdo_q;
  reg shift_q;
  reg [3:0] tap_d;
  wire tck_rise;
  wire tck_fall;

  assign tck_rise = tck & ~tck_q;
  assign tck_fall = ~tck & tck_q;
  assign test_pullup_en = 1'b1; // undriven test pins float high

  // standard next-state table
  always @*
  begin
    case (tap_q)
      `PSP_TAP_RESET: tap_d = tms ? `PSP_TAP_RESET : `PSP_TAP_IDLE;
      `PSP_TAP_IDLE: tap_d = tms ? `PSP_TAP_SEL_DR : `PSP_TAP_IDLE;
      `PSP_TAP_SEL_DR: tap_d = tms ? `PSP_TAP_SEL_IR : `PSP_TAP_CAP_DR;
      `PSP_TAP_CAP_DR: tap_d = tms ? `PSP_TAP_EX1_DR : `PSP_TAP_SH_DR;
      `PSP_TAP_SH_DR: tap_d = tms ? `PSP_TAP_EX1_DR : `PSP_TAP_SH_DR;
      `PSP_TAP_EX1_DR: tap_d = tms ? `PSP_TAP_UP_DR : `PSP_TAP_PA_DR;
      `PSP_TAP_PA_DR: tap_d = tms ? `PSP_TAP_EX2_DR : `PSP_TAP_PA_DR;
      `PSP_TAP_EX2_DR: tap_d = tms ? `PSP_TAP_UP_DR : `PSP_TAP_SH_DR;
      `PSP_TAP_UP_DR: tap_d = tms ? `PSP_TAP_SEL_DR : `PSP_TAP_IDLE;
      `PSP_TAP_SEL_IR: tap_d = tms ? `PSP_TAP_RESET : `PSP_TAP_CAP_IR;
      `PSP_TAP_CAP_IR: tap_d = tms ? `PSP_TAP_EX1_IR : `PSP_TAP_SH_IR;
      `PSP_TAP_SH_IR: tap_d = tms ? `PSP_TAP_EX1_IR : `PSP_TAP_SH_IR;
      `PSP_TAP_EX1_IR: tap_d = tms ? `PSP_TAP_UP_IR : `PSP_TAP_PA_IR;
      `PSP_TAP_PA_IR: tap_d = tms ? `PSP_TAP_EX2_IR : `PSP_TAP_PA_IR;
      `PSP_TAP_EX2_IR: tap_d = tms ? `PSP_TAP_UP_IR : `PSP_TAP_SH_IR;
      `PSP_TAP_UP_IR: tap_d = tms ? `PSP_TAP_SEL_DR : `PSP_TAP_IDLE;
      default: tap_d = `PSP_TAP_RESET;
    endcase
  end

  // test reset overrides tck at the next pclk edge, checked before any clocked step
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tck_q <= 1'b1;
      tap_q <= `PSP_TAP_RESET;
      tdo_q <= 1'b0;
      shift_q <= 1'b0;
    end
    else
    begin
      tck_q <= tck;
      if (!trst_n)
      begin
        tap_q <= `PSP_TAP_RESET;
        shift_q <= 1'b0;
      end
      else
      begin
        if (tck_rise)
          tap_q <= tap_d;
        // output changes on every falling tck; its enable is set only while shifting
        if (tck_fall)
        begin
          shift_q <= (tap_q == `PSP_TAP_SH_DR) || (tap_q == `PSP_TAP_SH_IR);
          tdo_q <= tdi; // no scan chain here: bypass behaviour
        end
      end
    end
  end

  // combinational release so test reset frees the pin without a clock
  assign tdo_o = tdo_q;
  assign tdo_oe = shift_q & trst_n;

  // =====================================================
  // expansion port direction
  // 00 inputs, 01 outputs gated by control pin high, 10 gated low, 11 always out
  function port_drive;
    input [1:0] en;
    input pin;
    begin
      case (en)
        2'b00: port_drive = 1'b0;
        2'b01: port_drive = pin;
        2'b10: port_drive = ~pin;
        default: port_drive = 1'b1;
      endcase
    end
  endfunction

  // one direction per port, shared by every pin of that port
  wire x_drv;
  wire i_drv;
  reg xvref_q;

  assign x_drv = port_drive(xport_en_q, expansion_port_output_control_pin);
  assign i_drv = port_drive(iport_en_q, image_port_oe_pin);

  // vertical reference form; registered so the pin comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xvref_q <= 1'b0;
    else
    begin
      case (vref_form_q)
        2'b00: xvref_q <= dec_vref;
        2'b01: xvref_q <= dec_vsync;
        2'b10: xvref_q <= dec_vgate;
        default: xvref_q <= ~dec_vref;
      endcase
    end
  end

  // per-bit enables; far side keeps off while x_drv is high
  genvar g;
  generate
    for (g = 0; g < XW; g = g + 1)
    begin : g_xpd
      assign expansion_port_data_pins_oe[g] = x_drv;
    end
  endgenerate

  // decoder sources pass straight out; only the vertical reference is retimed
  assign expansion_port_data_pins_o = dec_data;
  assign expansion_port_clock_pin_o = dec_clk;
  assign expansion_port_clock_pin_oe = x_drv;
  assign expansion_port_qualifier_pin_o = dec_qual;
  assign expansion_port_qualifier_pin_oe = x_drv;
  assign expansion_port_ready_pin_o = dec_ready;
  assign expansion_port_ready_pin_oe = x_drv;
  assign expansion_horizontal_ref_pin_o = dec_href;
  assign expansion_horizontal_ref_pin_oe = x_drv;
  assign expansion_vertical_ref_pin_o = xvref_q;
  assign expansion_vertical_ref_pin_oe = x_drv;
  // input data is masked while we drive, to avoid reading our own output
  assign xport_in_data = x_drv ? {XW{1'b0}} : expansion_port_data_pins_i;

  // =====================================================
  // image port
  // field and pin combine the same way as on the expansion port
  assign image_port_main_data_pins_o = scl_main;
  assign image_port_main_data_pins_oe = i_drv;
  assign image_port_chroma_pins_o = scl_chroma;
  assign image_port_chroma_pins_oe = i_drv;
  assign image_port_clock_pin_o = scl_clk;
  assign image_port_clock_pin_oe = i_drv;
  assign image_port_qualifier_pin_o = scl_qual;
  assign image_port_qualifier_pin_oe = i_drv;

  // oscillator passes straight through; a flop would halve it
  assign aux_oscillator_output = xtal_osc;

endmodule // psp_top

// File: tb/psp_board_model.sv
// board side: strap resistors and the far device on the expansion data lines
`timescale 1ns/10ps
module psp_board_model
#(
  parameter XW = 8
)
(
  // strap resistors fitted
  input wire addr_res,
  input wire xtal_res,
  // decoder side of the expansion data lines
  input wire [XW-1:0] dev_o,
  input wire [XW-1:0] dev_oe,
  input wire [XW-1:0] ext_val,
  // resolved pins
  output wire addr_pin,
  output wire xtal_pin,
  output wire [XW-1:0] data_wire
);
  // an unfitted resistor leaves the internal pull-down in charge
  assign addr_pin = addr_res;
  assign xtal_pin = xtal_res;
  // far device lets go of every line the decoder drives, so no contention
  assign data_wire = (dev_oe & dev_o) | (~dev_oe & ext_val);
endmodule // psp_board_model

// File: tb/psp_checker.sv
// concurrent checks on the strap, test and port-enable pins of psp_top
`timescale 1ns/10ps
`include "psp_consts.vh"
module psp_checker
#(
  parameter XW = 8,
  parameter IW = 8
)
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // straps
  input wire address_strap_pin_i,
  input wire crystal_select_strap_pin_i,
  input wire address_strap_pin_oe,
  input wire crystal_select_strap_pin_oe,
  input wire strap_pulldown_en,
  input wire [6:0] slave_addr,
  input wire xtal_is_high,
  input wire [15:0] xtal_khz,
  // test port
  input wire trst_n,
  input wire tdo_oe,
  input wire test_pullup_en,
  // video ports
  input wire [XW-1:0] dec_data,
  input wire [XW-1:0] expansion_port_data_pins_o,
  input wire [XW-1:0] expansion_port_data_pins_oe,
  input wire expansion_port_clock_pin_oe,
  input wire [XW-1:0] xport_in_data,
  input wire [IW-1:0] scl_main,
  input wire [IW-1:0] image_port_main_data_pins_o,
  input wire image_port_main_data_pins_oe,
  input wire image_port_clock_pin_oe,
  input wire xtal_osc,
  input wire aux_oscillator_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================================
  // straps are taken at the first edge after release; later edges must hold them
  sequence s_strap_edge;
    $past(presetn, 1) && !$past(presetn, 2);
  endsequence
  sequence s_settled;
    $past(presetn, 2);
  endsequence
  AST_STRAP_DIR: assert property (!address_strap_pin_oe && !crystal_select_strap_pin_oe)
    else $error("strap pin driven");
  AST_PULLS: assert property (strap_pulldown_en && test_pullup_en)
    else $error("pull enable missing");
  AST_ADDR_PICK: assert property (s_strap_edge |->
    slave_addr == ($past(address_strap_pin_i) ? `PSP_SLV_ADDR_HI : `PSP_SLV_ADDR_LO))
    else $error("slave address decode wrong");
  AST_XTAL_PICK: assert property (s_strap_edge |-> xtal_is_high == $past(crystal_select_strap_pin_i)
    && xtal_khz == (xtal_is_high ? `PSP_XTAL_KHZ_HI : `PSP_XTAL_KHZ_LO)) else $error("crystal decode wrong");
  AST_STRAP_HOLD: assert property (s_settled |-> $stable(slave_addr) && $stable(xtal_is_high))
    else $error("strap config moved");
  AST_TRST_OFF: assert property (!trst_n |-> !tdo_oe)
    else $error("test output driven in test reset");
  AST_XPORT_GROUP: assert property (expansion_port_data_pins_oe == {XW{expansion_port_clock_pin_oe}})
    else $error("expansion enables split");
  AST_XPORT: assert property (expansion_port_clock_pin_oe |->
    expansion_port_data_pins_o == dec_data && xport_in_data == '0) else $error("expansion drive wrong");
  AST_IPORT: assert property (image_port_main_data_pins_oe == image_port_clock_pin_oe &&
    (image_port_clock_pin_oe -> image_port_main_data_pins_o == scl_main)) else $error("image drive wrong");
  AST_AUX: assert property (aux_oscillator_output == xtal_osc)
    else $error("aux clock wrong");
endmodule // psp_checker

bind psp_top psp_checker #(.XW(XW), .IW(IW)) chk_u (.pclk(pclk), .presetn(presetn),
  .address_strap_pin_i(address_strap_pin_i), .crystal_select_strap_pin_i(crystal_select_strap_pin_i),
  .address_strap_pin_oe(address_strap_pin_oe), .crystal_select_strap_pin_oe(crystal_select_strap_pin_oe),
  .strap_pulldown_en(strap_pulldown_en), .slave_addr(slave_addr), .xtal_is_high(xtal_is_high),
  .xtal_khz(xtal_khz), .trst_n(trst_n), .tdo_oe(tdo_oe), .test_pullup_en(test_pullup_en),
  .dec_data(dec_data), .expansion_port_data_pins_o(expansion_port_data_pins_o),
  .expansion_port_data_pins_oe(expansion_port_data_pins_oe),
  .expansion_port_clock_pin_oe(expansion_port_clock_pin_oe), .xport_in_data(xport_in_data),
  .scl_main(scl_main), .image_port_main_data_pins_o(image_port_main_data_pins_o),
  .image_port_main_data_pins_oe(image_port_main_data_pins_oe),
  .image_port_clock_pin_oe(image_port_clock_pin_oe), .xtal_osc(xtal_osc),
  .aux_oscillator_output(aux_oscillator_output));

// File: tb/testbench.sv
// self-checking bench for strap capture, test port and port enables
`timescale 1ns/10ps
`include "psp_consts.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic err, addr_res = 0, xtal_res = 0, tck = 0, tms = 1, tdi = 0, trst_n = 0, xctl = 0, ipin = 0;
  logic [7:0] dec_data = 0, ext_val = 0, scl_main = 0, scl_chroma = 0;
  logic dec_clk = 0, dec_qual = 0, dec_ready = 0, dec_href = 0, dec_vref = 0, dec_vsync = 0, dec_vgate = 0;
  logic scl_clk = 0, scl_qual = 0, xtal_osc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, addr_pin, xtal_pin, xport_clk_oe, xvr_o, iport_clk_oe, tdo_o, tdo_oe, xtal_hi;
  wire [6:0] slave_addr;
  wire [15:0] khz;
  wire [7:0] xd_o, xd_oe, xd_w, xin;
  int fails = 0;
  int checks_done = 0;
  // =====================================================
  // design, board model and clock
  psp_top #(.XW(8), .IW(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_strap_pin_i(addr_pin), .crystal_select_strap_pin_i(xtal_pin), .address_strap_pin_oe(),
    .crystal_select_strap_pin_oe(), .strap_pulldown_en(), .slave_addr(slave_addr), .xtal_is_high(xtal_hi),
    .xtal_khz(khz), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .test_pullup_en(), .expansion_port_output_control_pin(xctl), .dec_data(dec_data), .dec_clk(dec_clk),
    .dec_qual(dec_qual), .dec_ready(dec_ready), .dec_href(dec_href), .dec_vref(dec_vref),
    .dec_vsync(dec_vsync), .dec_vgate(dec_vgate), .expansion_port_data_pins_i(xd_w),
    .expansion_port_data_pins_o(xd_o), .expansion_port_data_pins_oe(xd_oe), .expansion_port_clock_pin_o(),
    .expansion_port_clock_pin_oe(xport_clk_oe), .expansion_port_qualifier_pin_o(),
    .expansion_port_qualifier_pin_oe(), .expansion_port_ready_pin_o(), .expansion_port_ready_pin_oe(),
    .expansion_horizontal_ref_pin_o(), .expansion_horizontal_ref_pin_oe(),
    .expansion_vertical_ref_pin_o(xvr_o), .expansion_vertical_ref_pin_oe(), .xport_in_data(xin),
    .image_port_oe_pin(ipin), .scl_main(scl_main), .scl_chroma(scl_chroma), .scl_clk(scl_clk),
    .scl_qual(scl_qual), .image_port_main_data_pins_o(), .image_port_main_data_pins_oe(),
    .image_port_chroma_pins_o(), .image_port_chroma_pins_oe(), .image_port_clock_pin_o(),
    .image_port_clock_pin_oe(iport_clk_oe), .image_port_qualifier_pin_o(), .image_port_qualifier_pin_oe(),
    .xtal_osc(xtal_osc), .aux_oscillator_output());
  psp_board_model #(.XW(8)) board_u (.addr_res(addr_res), .xtal_res(xtal_res), .dev_o(xd_o),
    .dev_oe(xd_oe), .ext_val(ext_val), .addr_pin(addr_pin), .xtal_pin(xtal_pin), .data_wire(xd_w));
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  // random decoder and scaler sources, frozen while a latched value is judged;
  // seeded here since each process draws from its own generator
  initial
  begin
    void'($urandom(39));
    forever
    begin
      @(posedge pclk);
      if (!hold)
      begin
        {dec_data, scl_main, scl_chroma, ext_val} <= $urandom;
        {dec_clk, dec_qual, dec_ready, dec_href, dec_vref} <= $urandom;
        {dec_vsync, dec_vgate, scl_clk, scl_qual, xtal_osc} <= $urandom;
      end
    end
  end
  // =====================================================
  // tasks and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits on pready as long as it takes, only the watchdog ends a dead one
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    addr_res <= s[0];
    xtal_res <= s[1];
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
  endtask
  // test clock is slow against pclk so each level is seen by the sampler
  task automatic tpulse(input logic m);
    tms <= m;
    repeat (3) @(posedge pclk);
    tck <= 1;
    repeat (3) @(posedge pclk);
    tck <= 0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic drv(input logic [1:0] en, input logic p);
    return en == 2'b11 || (en == 2'b01 && p) || (en == 2'b10 && !p);
  endfunction
  function automatic logic vform(input logic [1:0] f, input logic v, input logic s, input logic g);
    return f == 2'd0 ? v : f == 2'd1 ? s : f == 2'd2 ? g : !v;
  endfunction
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      do_reset(s[1:0]);
      @(negedge pclk);
      check(slave_addr, s[0] ? `PSP_SLV_ADDR_HI : `PSP_SLV_ADDR_LO);
      check(khz, s[1] ? `PSP_XTAL_KHZ_HI : `PSP_XTAL_KHZ_LO);
      apb(1, `PSP_ADDR_STRAP, 32'h0000_0003);
      apb(0, `PSP_ADDR_STRAP, 32'h0000_0000);
      check(rd, s);
      addr_res <= ~s[0];
      xtal_res <= ~s[1];
      repeat (4) @(posedge pclk);
      check({xtal_hi, slave_addr}, {s[1], s[0] ? `PSP_SLV_ADDR_HI : `PSP_SLV_ADDR_LO});
    end
    apb(0, 12'h100, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    $display("strap test done");
    for (int e = 0; e < 8; e++)
    begin
      apb(1, `PSP_ADDR_XCTRL, e & 3);
      apb(1, `PSP_ADDR_ICTRL, e & 3);
      xctl <= e[2];
      ipin <= e[2];
      @(negedge pclk);
      check(xport_clk_oe, drv(e[1:0], e[2]));
      check(xin, drv(e[1:0], e[2]) ? 8'h00 : ext_val);
      check(iport_clk_oe, drv(e[1:0], e[2]));
    end
    $display("port enable test done");
    apb(1, `PSP_ADDR_XCTRL, 32'h0000_0003);
    for (int f = 0; f < 12; f++)
    begin
      apb(1, `PSP_ADDR_XFMT, (f & 3) << 4);
      hold <= 1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check(xvr_o, vform(f[1:0], dec_vref, dec_vsync, dec_vgate));
      hold <= 0;
    end
    $display("vertical reference test done");
    apb(0, `PSP_ADDR_TAPST, 32'h0000_0000);
    check(rd, `PSP_TAP_RESET);
    trst_n <= 1;
    tdi <= 1;
    for (int i = 0; i < 4; i++)
      tpulse(i == 1);
    @(negedge pclk);
    check({tdo_oe, tdo_o}, 2'b11);
    apb(0, `PSP_ADDR_TAPST, 32'h0000_0000);
    check(rd, `PSP_TAP_SH_DR);
    trst_n <= 0;
    #1;
    check(tdo_oe, 1'b0);
    apb(0, `PSP_ADDR_TAPST, 32'h0000_0000);
    check(rd, `PSP_TAP_RESET);
    $display("test port test done");
    summarize();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge pclk);
    fails++;
    $display("watchdog expired");
    summarize();
  end
endmodule // testbench
